// File: include/buck_regulator_pkg.sv
package buck_regulator_pkg;

   // Register byte offsets on the APB bus.
   localparam logic [11:0] CTRL_OFFSET   = 12'h000;
   localparam logic [11:0] STATUS_OFFSET = 12'h004;
   localparam logic [11:0] MASK_OFFSET   = 12'h008;
   localparam logic [11:0] STATE_OFFSET  = 12'h00C;
   localparam logic [11:0] LEVEL_OFFSET  = 12'h010;
   localparam logic [11:0] PHASE_OFFSET  = 12'h014;

   // Field positions in the control register.
   localparam int CODE_LSB  = 0;
   localparam int RUN_LSB   = 5;
   localparam int STBY_LSB  = 7;
   localparam int ILIM_LSB  = 9;
   localparam int PHASE_LSB = 11;

   // Field positions in the state and level registers.
   localparam int ST_MODE_LSB  = 0;
   localparam int ST_EN_BIT    = 2;
   localparam int ST_DIS_BIT   = 3;
   localparam int ST_STBY_BIT  = 4;
   localparam int ST_CODE_LSB  = 5;
   localparam int ST_IND_LSB   = 10;
   localparam int ST_LOAD_BIT  = 12;
   localparam int LVL_PEAK_LSB = 16;

   // Mode field encodings.
   localparam logic [1:0] MODE_OFF      = 2'h0;
   localparam logic [1:0] MODE_PWM      = 2'h1;
   localparam logic [1:0] MODE_PFM      = 2'h2;
   localparam logic [1:0] MODE_AUTOSKIP = 2'h3;

   // Values after reset.
   localparam logic [2:0] PHASE_RESET = 3'h7;
   localparam logic [1:0] ILIM_RESET  = 2'h0;
   localparam logic       MASK_RESET  = 1'h0;

   // Cycles for the pin synchronisers to settle before the defaults load.
   localparam logic [1:0] INIT_WAIT = 2'h2;

   // Output discharge time before re-enable, and the clock rate.
   localparam int DISCHARGE_US = 100;
   localparam int CLK_MHZ      = 100;
   localparam int DISCHARGE_CYCLES = DISCHARGE_US * CLK_MHZ;

   // Output set point in millivolts for each voltage code.
   localparam logic [12:0] VOUT_MV [0:31] = '{
      13'h03E8, 13'h044C, 13'h04B0, 13'h04E2, 13'h0514, 13'h0546,
      13'h05DC, 13'h0640, 13'h0708, 13'h073A, 13'h07D0, 13'h0834,
      13'h0866, 13'h08CA, 13'h08FC, 13'h0960, 13'h09C4, 13'h0AF0,
      13'h0C4E, 13'h0C80, 13'h0CB2, 13'h0CE4, 13'h0D16, 13'h0D48,
      13'h0DAC, 13'h0ED8, 13'h0FA0, 13'h1004, 13'h1004, 13'h1004,
      13'h1004, 13'h1004};

   // Typical peak current limit in milliamps.
   localparam logic [12:0] ILIM_MA [0:3] = '{
      13'h0834, 13'h0A28, 13'h0BB8, 13'h1194};

   // Phase shift in degrees.
   localparam logic [8:0] PHASE_DEG [0:7] = '{
      9'h02D, 9'h05A, 9'h087, 9'h0B4, 9'h0E1, 9'h10E, 9'h13B, 9'h000};

   // Inductor value in nanohenries; zero marks the reserved code.
   localparam logic [10:0] IND_NH [0:3] = '{
      11'h3E8, 11'h1D6, 11'h5DC, 11'h000};

endpackage

// File: rtl/pin_sync.sv
// Two-stage synchroniser for a vector of pin levels.
module pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] din,
   output      logic [WIDTH-1:0] dout
);

   typedef struct packed {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
   } sync_s;

   sync_s r;
   sync_s next_r;

   // The first stage feeds only the second stage.
   always_comb begin
      next_r        = r;
      next_r.first  = din;
      next_r.second = r.first;
   end

   // Both stages clear under reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign dout = r.second;

endmodule

// File: rtl/buck_regulator_control.sv
module buck_regulator_control #(
   parameter int DISCHARGE_CYCLES = buck_regulator_pkg::DISCHARGE_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   input  wire logic [4:0]  otp_voltage_default,
   input  wire logic        otp_in_sequence,
   input  wire logic [1:0]  inductor_select,
   input  wire logic        system_on,
   input  wire logic        standby_req,
   output      logic        regulator_enable,
   output      logic [1:0]  regulator_mode_field,
   output      logic        discharge_en,
   output      logic [12:0] setpoint_mv,
   output      logic [12:0] peak_limit_ma,
   output      logic [8:0]  phase_shift_deg,
   output      logic [10:0] inductor_nh,
   output      logic        irq_out_n
);

   localparam int CNT_W = $clog2(DISCHARGE_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST =
      CNT_W'(DISCHARGE_CYCLES - 1);

   typedef enum logic [1:0] {
      ST_INIT,
      ST_ACTIVE,
      ST_DISCHARGE
   } fsm_e;

   typedef struct packed {
      logic             pready;
      logic             pslverr;
      logic [31:0]      prdata;
      logic [1:0]       init_cnt;
      logic             loaded;
      fsm_e             fsm;
      logic [CNT_W-1:0] cnt;
      logic [4:0]       code;
      logic [1:0]       run_mode;
      logic [1:0]       stby_mode;
      logic [1:0]       ilim;
      logic [2:0]       phase;
      logic             mask;
      logic             status;
      logic [4:0]       applied;
      logic             reg_enable;
      logic [1:0]       reg_mode;
      logic             discharge;
      logic [12:0]      setpoint;
      logic [12:0]      peak_ma;
      logic [8:0]       phase_deg;
      logic [10:0]      ind_nh;
      logic             irq_n;
   } state_s;

   state_s      r;
   state_s      next_r;
   logic [9:0]  pins_s;
   logic [4:0]  otp_code_s;
   logic        otp_seq_s;
   logic [1:0]  ind_sel_s;
   logic        sys_on_s;
   logic        stby_s;
   logic        access;
   logic        done;
   logic        hit;
   logic [31:0] rd_val;
   logic [1:0]  sel_mode;
   logic        want_on;
   logic        code_change;

   // All pin levels pass two flip-flops before any logic reads them.
   pin_sync #(
      .WIDTH(10)
   ) u_pin_sync (
      .pclk   (pclk),
      .presetn(presetn),
      .din    ({otp_voltage_default, otp_in_sequence, inductor_select,
                system_on, standby_req}),
      .dout   (pins_s)
   );

   assign otp_code_s = pins_s[9:5];
   assign otp_seq_s  = pins_s[4];
   assign ind_sel_s  = pins_s[3:2];
   assign sys_on_s   = pins_s[1];
   assign stby_s     = pins_s[0];

   // Address decode and read data for the register map.
   always_comb begin
      hit    = 1'b1;
      rd_val = '0;
      case (paddr)
         buck_regulator_pkg::CTRL_OFFSET: begin
            rd_val[buck_regulator_pkg::CODE_LSB +: 5]  = r.code;
            rd_val[buck_regulator_pkg::RUN_LSB +: 2]   = r.run_mode;
            rd_val[buck_regulator_pkg::STBY_LSB +: 2]  = r.stby_mode;
            rd_val[buck_regulator_pkg::ILIM_LSB +: 2]  = r.ilim;
            rd_val[buck_regulator_pkg::PHASE_LSB +: 3] = r.phase;
         end
         buck_regulator_pkg::STATUS_OFFSET: begin
            rd_val[0] = r.status;
         end
         buck_regulator_pkg::MASK_OFFSET: begin
            rd_val[0] = r.mask;
         end
         buck_regulator_pkg::STATE_OFFSET: begin
            rd_val[buck_regulator_pkg::ST_MODE_LSB +: 2] = r.reg_mode;
            rd_val[buck_regulator_pkg::ST_EN_BIT]   = r.reg_enable;
            rd_val[buck_regulator_pkg::ST_DIS_BIT]  = r.discharge;
            rd_val[buck_regulator_pkg::ST_STBY_BIT] = stby_s;
            rd_val[buck_regulator_pkg::ST_CODE_LSB +: 5] = r.applied;
            rd_val[buck_regulator_pkg::ST_IND_LSB +: 2]  = ind_sel_s;
            rd_val[buck_regulator_pkg::ST_LOAD_BIT] = r.loaded;
         end
         buck_regulator_pkg::LEVEL_OFFSET: begin
            rd_val[12:0] = r.setpoint;
            rd_val[buck_regulator_pkg::LVL_PEAK_LSB +: 13] = r.peak_ma;
         end
         buck_regulator_pkg::PHASE_OFFSET: begin
            rd_val[8:0]   = r.phase_deg;
            rd_val[26:16] = r.ind_nh;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // Bus phases: the first access cycle prepares the answer, the
   // second completes the transfer and commits any side effect.
   assign access = psel & penable & ~r.pready;
   assign done   = psel & penable & r.pready;

   // The mode in force follows the system state.
   always_comb begin
      sel_mode = stby_s ? r.stby_mode : r.run_mode;
      want_on  = r.loaded & sys_on_s &
                 (sel_mode != buck_regulator_pkg::MODE_OFF);
   end

   // A voltage write that alters the code while the output is live.
   assign code_change = done & pwrite & hit &
      (paddr == buck_regulator_pkg::CTRL_OFFSET) &
      (pwdata[buck_regulator_pkg::CODE_LSB +: 5] != r.code) &
      r.reg_enable;

   // Next-state logic for the whole block.
   always_comb begin
      next_r         = r;
      next_r.pready  = 1'b0;
      next_r.pslverr = 1'b0;

      // Answer one cycle into the access phase; unmapped reads give zero.
      if (access) begin
         next_r.pready  = 1'b1;
         next_r.prdata  = rd_val;
         next_r.pslverr = ~hit;
      end

      // Register writes take effect on the completing edge.
      if (done && pwrite && hit) begin
         case (paddr)
            buck_regulator_pkg::CTRL_OFFSET: begin
               if (r.loaded) begin
                  next_r.code =
                     pwdata[buck_regulator_pkg::CODE_LSB +: 5];
                  next_r.run_mode =
                     pwdata[buck_regulator_pkg::RUN_LSB +: 2];
                  next_r.stby_mode =
                     pwdata[buck_regulator_pkg::STBY_LSB +: 2];
                  next_r.ilim =
                     pwdata[buck_regulator_pkg::ILIM_LSB +: 2];
                  next_r.phase =
                     pwdata[buck_regulator_pkg::PHASE_LSB +: 3];
               end
            end
            buck_regulator_pkg::MASK_OFFSET: begin
               next_r.mask = pwdata[0];
            end
            default: begin
               next_r.mask = r.mask;
            end
         endcase
      end

      // A read of the status clears only what that read returned.
      if (done && !pwrite &&
          (paddr == buck_regulator_pkg::STATUS_OFFSET)) begin
         next_r.status = r.status & ~r.prdata[0];
      end

      // Sequencer for default load, normal running and discharge.
      case (r.fsm)
         ST_INIT: begin
            next_r.init_cnt = r.init_cnt + 2'h1;
            if (r.init_cnt == buck_regulator_pkg::INIT_WAIT) begin
               next_r.loaded  = 1'b1;
               next_r.fsm     = ST_ACTIVE;
               next_r.code    = otp_code_s;
               next_r.applied = otp_code_s;
               next_r.phase   = buck_regulator_pkg::PHASE_RESET;
               next_r.ilim    = buck_regulator_pkg::ILIM_RESET;
               next_r.run_mode = otp_seq_s ?
                  buck_regulator_pkg::MODE_AUTOSKIP :
                  buck_regulator_pkg::MODE_OFF;
               next_r.stby_mode = otp_seq_s ?
                  buck_regulator_pkg::MODE_AUTOSKIP :
                  buck_regulator_pkg::MODE_OFF;
            end
         end
         ST_ACTIVE: begin
            // While off, the applied code simply tracks the written one.
            next_r.applied = r.code;
            if (code_change) begin
               next_r.fsm = ST_DISCHARGE;
               next_r.cnt = '0;
            end
         end
         ST_DISCHARGE: begin
            next_r.cnt = r.cnt + CNT_W'(1);
            if (r.cnt == CNT_LAST) begin
               next_r.fsm     = ST_ACTIVE;
               next_r.applied = next_r.code;
               next_r.cnt     = '0;
            end
         end
         default: begin
            next_r.fsm = ST_INIT;
         end
      endcase

      // Mode decode; a standby switch alone never changes the code.
      next_r.reg_mode   = want_on ? sel_mode :
                          buck_regulator_pkg::MODE_OFF;
      next_r.discharge  = (next_r.fsm == ST_DISCHARGE);
      next_r.reg_enable = want_on & (next_r.fsm == ST_ACTIVE);

      // Any change of the operating mode raises the sticky flag.
      if (next_r.reg_mode != r.reg_mode) begin
         next_r.status = 1'b1;
      end

      // Decoded levels from the lookup tables.
      next_r.setpoint  =
         buck_regulator_pkg::VOUT_MV[next_r.applied];
      next_r.peak_ma   =
         buck_regulator_pkg::ILIM_MA[next_r.ilim];
      next_r.phase_deg =
         buck_regulator_pkg::PHASE_DEG[next_r.phase];
      next_r.ind_nh    =
         buck_regulator_pkg::IND_NH[ind_sel_s];

      // Level interrupt, low while an unmasked flag is set.
      next_r.irq_n = ~(next_r.status & ~next_r.mask);
   end

   // State register; control state takes fixed values under reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r           <= '0;
         r.fsm       <= ST_INIT;
         r.phase     <= buck_regulator_pkg::PHASE_RESET;
         r.ilim      <= buck_regulator_pkg::ILIM_RESET;
         r.mask      <= buck_regulator_pkg::MASK_RESET;
         r.irq_n     <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // Every output comes straight from the state register.
   assign prdata               = r.prdata;
   assign pready               = r.pready;
   assign pslverr              = r.pslverr;
   assign regulator_enable     = r.reg_enable;
   assign regulator_mode_field = r.reg_mode;
   assign discharge_en         = r.discharge;
   assign setpoint_mv          = r.setpoint;
   assign peak_limit_ma        = r.peak_ma;
   assign phase_shift_deg      = r.phase_deg;
   assign inductor_nh          = r.ind_nh;
   assign irq_out_n            = r.irq_n;

endmodule

// File: test/buck_regulator_control_chk.sv
module buck_regulator_control_chk #(
   parameter int DISCHARGE_CYCLES = 8
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        regulator_enable,
   input wire logic [1:0]  regulator_mode_field,
   input wire logic        discharge_en,
   input wire logic [12:0] setpoint_mv,
   input wire logic [12:0] peak_limit_ma,
   input wire logic [8:0]  phase_shift_deg,
   input wire logic [10:0] inductor_nh
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] dcnt;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Counts how long the output has been discharging.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) dcnt <= 32'h0;
      else if (discharge_en) dcnt <= dcnt + 32'h1;
      else dcnt <= 32'h0;
   end

   // Steps of an access and of a voltage change.
   sequence s_access_start;
      psel && $rose(penable);
   endsequence
   sequence s_restart;
      (dcnt == 32'(DISCHARGE_CYCLES)) ##[0:1] regulator_enable;
   endsequence

   a_ready_wait: assert property (s_access_start |=> pready)
      else $error("ready missing in second access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   a_off_disabled: assert property (
      regulator_enable |-> regulator_mode_field != buck_regulator_pkg::MODE_OFF)
      else $error("regulator on with mode off");
   a_discharge_off: assert property (discharge_en |-> !regulator_enable)
      else $error("regulator on while discharging");
   a_discharge_len: assert property ($fell(discharge_en) |-> s_restart)
      else $error("discharge length or restart wrong");
   a_setpoint_hold: assert property (
      $changed(setpoint_mv) |-> !$past(regulator_enable))
      else $error("set point moved while regulating");
   a_phase_legal: assert property (
      phase_shift_deg % 45 == 0 && phase_shift_deg <= 9'h13B)
      else $error("phase shift not a legal step");
   a_peak_legal: assert property (peak_limit_ma inside
      {13'h0000, 13'h0834, 13'h0A28, 13'h0BB8, 13'h1194})
      else $error("peak limit not a legal value");
   a_ind_legal: assert property (inductor_nh inside
      {11'h000, 11'h3E8, 11'h1D6, 11'h5DC})
      else $error("inductor value not legal");
endmodule

bind buck_regulator_control buck_regulator_control_chk #(
   .DISCHARGE_CYCLES(DISCHARGE_CYCLES)
) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .regulator_enable(regulator_enable),
   .regulator_mode_field(regulator_mode_field),
   .discharge_en(discharge_en), .setpoint_mv(setpoint_mv),
   .peak_limit_ma(peak_limit_ma), .phase_shift_deg(phase_shift_deg),
   .inductor_nh(inductor_nh)
);

// File: test/apb_host.sv
module apb_host (
   input  wire logic        pclk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   output      logic        psel,
   output      logic        penable,
   output      logic        pwrite,
   output      logic [11:0] paddr,
   output      logic [31:0] pwdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] rd;
   logic        err;

   // Bus idle at time zero.
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end

   // One transfer; request held until ready is seen at an edge.
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
   endtask
endmodule

// File: test/buck_regulator_control_tb.sv
module buck_regulator_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int VMV [32] = '{1000, 1100, 1200, 1250, 1300, 1350, 1500,
      1600, 1800, 1850, 2000, 2100, 2150, 2250, 2300, 2400, 2500, 2800,
      3150, 3200, 3250, 3300, 3350, 3400, 3500, 3800, 4000, 4100, 4100,
      4100, 4100, 4100};
   localparam int IMA [4] = '{2100, 2600, 3000, 4500};
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [4:0]  otp_voltage_default;
   logic        otp_in_sequence;
   logic [1:0]  inductor_select;
   logic        system_on;
   logic        standby_req;
   logic        regulator_enable;
   logic [1:0]  regulator_mode_field;
   logic        discharge_en;
   logic [12:0] setpoint_mv;
   logic [12:0] peak_limit_ma;
   logic [8:0]  phase_shift_deg;
   logic [10:0] inductor_nh;
   logic        irq_out_n;
   logic        saw;
   int          n_errors;
   int          num_checks;

   apb_host u_host (.pclk(pclk), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata));

   buck_regulator_control #(.DISCHARGE_CYCLES(8)) u_buck_regulator_control (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .otp_voltage_default(otp_voltage_default),
      .otp_in_sequence(otp_in_sequence), .inductor_select(inductor_select),
      .system_on(system_on), .standby_req(standby_req),
      .regulator_enable(regulator_enable),
      .regulator_mode_field(regulator_mode_field),
      .discharge_en(discharge_en), .setpoint_mv(setpoint_mv),
      .peak_limit_ma(peak_limit_ma), .phase_shift_deg(phase_shift_deg),
      .inductor_nh(inductor_nh), .irq_out_n(irq_out_n));

   // Free-running clock of 100 MHz.
   initial pclk = 1'b0;
   always #5 pclk = ~pclk;

   // Compares one value and counts the outcome.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
      end
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic wrap_up();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Register access shorthands.
   task automatic rd(input logic [11:0] a);
      u_host.xfer(1'b0, a, 32'h0);
   endtask
   task automatic ctrl(input logic [4:0] c, input logic [1:0] r, s, l,
                       input logic [2:0] p);
      u_host.xfer(1'b1, buck_regulator_pkg::CTRL_OFFSET, 32'({p, l, s, r, c}));
   endtask

   // Resets for ten cycles, then polls until the defaults have loaded.
   task automatic do_reset(input logic seq);
      @(posedge pclk);
      presetn <= 1'b0;
      otp_in_sequence <= seq;
      standby_req <= 1'b0;
      repeat (10) @(posedge pclk);
      chk(32'(irq_out_n), 32'h1);
      presetn <= 1'b1;
      repeat (20) begin
         rd(buck_regulator_pkg::STATE_OFFSET);
         if (u_host.rd[12] === 1'b1) break;
      end
      repeat (2) @(posedge pclk);
   endtask

   // Waits for a discharge to start and the regulator to come back.
   task automatic wait_on();
      saw = 1'b0;
      repeat (40) begin
         @(posedge pclk);
         if (discharge_en === 1'b1) saw = 1'b1;
         else if (saw && regulator_enable === 1'b1) break;
      end
   endtask

   // Power-up defaults with the regulator in the sequence.
   task automatic t_defaults();
      chk(32'(regulator_mode_field), 32'h3);
      chk(32'(setpoint_mv), 32'd1800);
      chk(32'(inductor_nh), 32'd470);
      chk(32'(phase_shift_deg), 32'h0);
      standby_req <= 1'b1;
      repeat (5) @(posedge pclk);
      chk(32'(regulator_mode_field), 32'h3);
      chk(32'(setpoint_mv), 32'd1800);
      standby_req <= 1'b0;
   endtask

   // Every voltage code, with limit setting i mod 4 and phase setting i mod 8.
   task automatic t_codes();
      for (int i = 0; i < 32; i++) begin
         ctrl(5'(i), 2'h3, 2'h3, 2'(i), 3'(i));
         wait_on();
         chk(32'(saw), 32'h1);
         chk(32'(setpoint_mv), 32'(VMV[i]));
         chk(32'(peak_limit_ma), 32'(IMA[i % 4]));
         chk(32'(phase_shift_deg),
             (i % 8 == 7) ? 32'h0 : 32'(45 * (i % 8 + 1)));
         rd(buck_regulator_pkg::STATE_OFFSET);
         chk(32'(u_host.rd[9:5]), 32'(i));
      end
   endtask

   // Mode codes, interrupt raise, clear, mask and standby switch.
   task automatic t_modes();
      rd(buck_regulator_pkg::STATUS_OFFSET);
      for (int m = 0; m < 4; m++) begin
         ctrl(5'h1F, 2'(m), 2'h3, 2'h3, 3'h7);
         repeat (3) @(posedge pclk);
         chk(32'(regulator_mode_field), 32'(m));
         chk(32'(regulator_enable), 32'(m != 0));
         chk(32'(irq_out_n), 32'h0);
         rd(buck_regulator_pkg::STATUS_OFFSET);
         chk(u_host.rd & 32'h1, 32'h1);
         repeat (2) @(posedge pclk);
         chk(32'(irq_out_n), 32'h1);
      end
      u_host.xfer(1'b1, buck_regulator_pkg::MASK_OFFSET, 32'h1);
      ctrl(5'h1F, 2'h1, 2'h2, 2'h3, 3'h7);
      repeat (3) @(posedge pclk);
      chk(32'(irq_out_n), 32'h1);
      rd(buck_regulator_pkg::STATUS_OFFSET);
      chk(u_host.rd & 32'h1, 32'h1);
      u_host.xfer(1'b1, buck_regulator_pkg::MASK_OFFSET, 32'h0);
      standby_req <= 1'b1;
      repeat (5) @(posedge pclk);
      chk(32'(regulator_mode_field), 32'h2);
      chk(32'(setpoint_mv), 32'd4100);
      chk(32'(irq_out_n), 32'h0);
      standby_req <= 1'b0;
      repeat (5) @(posedge pclk);
      chk(32'(regulator_mode_field), 32'h1);
      rd(12'hFFC);
      chk(32'(u_host.err), 32'h1);
      chk(u_host.rd, 32'h0);
   endtask

   // Second power-up outside the sequence, other programmed defaults.
   task automatic t_off_reset();
      otp_voltage_default <= 5'h11;
      inductor_select <= 2'h3;
      do_reset(1'b0);
      chk(32'(regulator_mode_field), 32'h0);
      chk(32'(regulator_enable), 32'h0);
      chk(32'(inductor_nh), 32'h0);
      rd(buck_regulator_pkg::STATE_OFFSET);
      chk(32'(u_host.rd[9:5]), 32'h11);
      standby_req <= 1'b1;
      repeat (5) @(posedge pclk);
      chk(32'(regulator_mode_field), 32'h0);
   endtask

   // Main sequence.
   initial begin
      presetn = 1'b0;
      otp_voltage_default = 5'h08;
      otp_in_sequence = 1'b1;
      inductor_select = 2'h1;
      system_on = 1'b1;
      standby_req = 1'b0;
      n_errors = 0;
      num_checks = 0;
      do_reset(1'b1);
      t_defaults();
      t_codes();
      t_modes();
      t_off_reset();
      wrap_up();
   end

   // Cuts a hang short after ten thousand cycles.
   initial begin
      #100000;
      n_errors++;
      wrap_up();
   end
endmodule
